// *** rtl/kip_cfg.svh ***
// Purpose: constants for the keyboard input port
// Assumes: included by bare name from rtl files
// Notes:   bit positions, widths, reset values and depths only
`ifndef KIP_CFG_SVH
`define KIP_CFG_SVH

// keyboard data width and buffer depth
`define KIP_DATA_W      8
`define KIP_FIFO_DEPTH  8
`define KIP_FIFO_AW     3

// port select compares the upper six address bits
`define KIP_ADDR_W      8
`define KIP_SEL_W       6
`define KIP_SEL_LSB     2

// status port bit positions
`define KIP_STAT_IRQ_BIT  0
`define KIP_STAT_STB_BIT  7

// reset values
`define KIP_DATA_RST    8'h00
`define KIP_VEC_RST     8'h00
`define KIP_VEC_ONE     8'h01

`endif

// *** rtl/kip_fifo.sv ***
// Purpose: small synchronous fifo holding keypress characters
// Assumes: one clock, writer and reader honour valid/ready
// Notes:   head word is shown combinationally on out_data
`timescale 1ns/1ns
module kip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  // fill level
  output logic      [AW:0]      count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // handshakes and flags
  assign in_ready  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign count     = count_reg;

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // kip_fifo

// *** rtl/kip_pkg.sv ***
// Purpose: types for the keyboard input port
// Assumes: nothing
// Notes:   bus answer state is one-hot
package kip_pkg;

  // bus answer states
  typedef enum logic [2:0] {
    KIP_IDLE = 3'b001,
    KIP_DATA = 3'b010,
    KIP_STAT = 3'b100
  } kip_ans_t;

endpackage

// *** rtl/kip_top.sv ***
// Purpose: latched parallel keyboard input port with keypress strobe
// Assumes: bus read strobes and address are synchronous to CLK
// Notes:   keyboard pins and switch settings are synchronised here
//
// Overview of operation
// [R1] reading the data port returns the latched keyboard character
// [R2] software checks a key arrived and was not already handled
// [R3] a strobe input beside eight data lines marks each keypress
// [R4] each strobe pulse sets the interrupt request latch
// [R5] status read shows the interrupt latch on bit 0
// [R6] status read shows the current raw strobe level on bit 7
// [R7] strobe polarity selectable: idles low by default, idles high otherwise
// [R8] eight data lines latched, first line is the least significant bit
// [R9] port selected when upper six address bits match six switches
// [R10] reading the data port clears the interrupt request latch; here only the read that takes the last buffered character clears it
`timescale 1ns/1ns
`include "kip_cfg.svh"
module kip_top (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  // keyboard connector
  input  wire logic [`KIP_DATA_W-1:0]     KBD_DATA,
  input  wire logic                       KBD_STROBE,
  // board settings
  input  wire logic                       STROBE_POLARITY_SELECT,
  input  wire logic [2:0]                 INTERRUPT_PRIORITY_SELECT,
  input  wire logic [`KIP_SEL_W-1:0]      ADDR_SWITCH,
  // processor input port access
  input  wire logic [`KIP_ADDR_W-1:0]     PORT_ADDR,
  input  wire logic                       PORT_READ,
  input  wire logic                       STATUS_READ,
  output logic      [`KIP_DATA_W-1:0]     DATA_OUT,
  output logic                            DATA_OE,
  // interrupt request
  output logic                            INT_REQ,
  output logic      [7:0]                 INT_VECTOR
);

  // synchronisers: first stage read only by the second
  logic [`KIP_DATA_W-1:0] kbd_data_s1_reg;
  logic [`KIP_DATA_W-1:0] kbd_data_s2_reg;
  logic                   kbd_stb_s1_reg;
  logic                   kbd_stb_s2_reg;
  logic                   pol_s1_reg;
  logic                   pol_s2_reg;
  logic [2:0]             prio_s1_reg;
  logic [2:0]             prio_s2_reg;
  logic [`KIP_SEL_W-1:0]  sw_s1_reg;
  logic [`KIP_SEL_W-1:0]  sw_s2_reg;

  // keypress capture
  logic                   stb_active;
  logic                   stb_active_d_reg;
  logic                   key_edge;
  logic                   pend_valid_reg;
  logic [`KIP_DATA_W-1:0] pend_data_reg;

  // fifo links
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [`KIP_DATA_W-1:0] fifo_out_data;
  logic [`KIP_FIFO_AW:0]  fifo_count;
  logic                   push;
  logic                   pop;

  // bus side
  logic                   data_hit;
  logic                   stat_hit;
  logic [`KIP_DATA_W-1:0] last_char_reg;
  logic                   irq_reg;
  logic                   irq_next;
  logic [`KIP_DATA_W-1:0] data_out_reg;
  logic                   data_oe_reg;
  logic [7:0]             vec_reg;
  kip_pkg::kip_ans_t      ans_next;

  // upper address bits against the switch setting
  function automatic logic kip_sel(
    input logic [`KIP_ADDR_W-1:0] addr,
    input logic [`KIP_SEL_W-1:0]  sw
  );
    kip_sel = (addr[`KIP_ADDR_W-1:`KIP_SEL_LSB] == sw);
  endfunction

  // status byte: latch on bit 0, raw strobe on bit 7
  function automatic logic [`KIP_DATA_W-1:0] kip_status(
    input logic irq,
    input logic stb
  );
    logic [`KIP_DATA_W-1:0] s;
    s = `KIP_DATA_RST;
    s[`KIP_STAT_IRQ_BIT] = irq;
    s[`KIP_STAT_STB_BIT] = stb;
    kip_status = s;
  endfunction

  // [R8] two-stage capture of data lines
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      kbd_data_s1_reg <= `KIP_DATA_RST;
      kbd_data_s2_reg <= `KIP_DATA_RST;
    end else begin
      kbd_data_s1_reg <= KBD_DATA;
      kbd_data_s2_reg <= kbd_data_s1_reg;
    end
  end

  // [R3] two-stage capture of strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      kbd_stb_s1_reg <= 1'b0;
      kbd_stb_s2_reg <= 1'b0;
    end else begin
      kbd_stb_s1_reg <= KBD_STROBE;
      kbd_stb_s2_reg <= kbd_stb_s1_reg;
    end
  end

  // settings synchronisers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pol_s1_reg  <= 1'b0;
      pol_s2_reg  <= 1'b0;
      prio_s1_reg <= 3'h0;
      prio_s2_reg <= 3'h0;
      sw_s1_reg   <= 6'h00;
      sw_s2_reg   <= 6'h00;
    end else begin
      pol_s1_reg  <= STROBE_POLARITY_SELECT;
      pol_s2_reg  <= pol_s1_reg;
      prio_s1_reg <= INTERRUPT_PRIORITY_SELECT;
      prio_s2_reg <= prio_s1_reg;
      sw_s1_reg   <= ADDR_SWITCH;
      sw_s2_reg   <= sw_s1_reg;
    end
  end

  // [R7] fold polarity so a keypress is a rise
  assign stb_active = kbd_stb_s2_reg ^ pol_s2_reg;

  // delayed copy for edge detection
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stb_active_d_reg <= 1'b0;
    end else begin
      stb_active_d_reg <= stb_active;
    end
  end

  // [R3] one event per strobe pulse
  assign key_edge = stb_active && !stb_active_d_reg;

  // holding latch waits while the fifo is full
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pend_valid_reg <= 1'b0;
      pend_data_reg  <= `KIP_DATA_RST;
    end else begin
      if (key_edge && (!pend_valid_reg || push)) begin
        // [R8] latch character on keypress
        pend_valid_reg <= 1'b1;
        pend_data_reg  <= kbd_data_s2_reg;
      end else if (push) begin
        pend_valid_reg <= 1'b0;
      end
    end
  end

  assign push = pend_valid_reg && fifo_in_ready;

  // character buffer
  kip_fifo #(
    .WIDTH (`KIP_DATA_W),
    .DEPTH (`KIP_FIFO_DEPTH),
    .AW    (`KIP_FIFO_AW)
  ) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (pend_valid_reg),
    .in_data   (pend_data_reg),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (data_hit),
    .count     (fifo_count)
  );

  // [R9] upper six bits compared, low two ignored
  assign data_hit = PORT_READ && kip_sel(PORT_ADDR, sw_s2_reg);
  assign stat_hit = STATUS_READ && !PORT_READ && kip_sel(PORT_ADDR, sw_s2_reg);
  assign pop      = data_hit && fifo_out_valid;

  // last character delivered, repeated when buffer is empty
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      last_char_reg <= `KIP_DATA_RST;
    end else if (pop) begin
      last_char_reg <= fifo_out_data;
    end
  end

  // [R4] keypress sets, [R10] last read clears; set wins
  always_comb begin
    irq_next = irq_reg;
    if (pop && (fifo_count == 4'h1)) begin
      irq_next = 1'b0;
    end
    if (push) begin
      irq_next = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // bus answer state: one cycle of drive per read
  always_comb begin
    ans_next = kip_pkg::KIP_IDLE;
    if (data_hit) begin
      ans_next = kip_pkg::KIP_DATA;
    end else if (stat_hit) begin
      ans_next = kip_pkg::KIP_STAT;
    end
  end

  // read data register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      data_out_reg <= `KIP_DATA_RST;
      data_oe_reg  <= 1'b0;
    end else begin
      case (ans_next)
        kip_pkg::KIP_DATA: begin
          // [R1] latch contents onto the bus
          data_out_reg <= fifo_out_valid ? fifo_out_data : last_char_reg;
          data_oe_reg  <= 1'b1;
        end
        kip_pkg::KIP_STAT: begin
          // [R5] [R6] latch bit 0, strobe bit 7
          data_out_reg <= kip_status(irq_reg, kbd_stb_s2_reg);
          data_oe_reg  <= 1'b1;
        end
        default: begin
          data_out_reg <= `KIP_DATA_RST;
          data_oe_reg  <= 1'b0;
        end
      endcase
    end
  end

  // [R4] vectored request on the selected priority line
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      vec_reg <= `KIP_VEC_RST;
    end else if (irq_next) begin
      vec_reg <= `KIP_VEC_ONE << prio_s2_reg;
    end else begin
      vec_reg <= `KIP_VEC_RST;
    end
  end

  // outputs straight from flops
  assign DATA_OUT   = data_out_reg;
  assign DATA_OE    = data_oe_reg;
  assign INT_REQ    = irq_reg;
  assign INT_VECTOR = vec_reg;

endmodule // kip_top

// *** tb/kip_chk.sv ***
// Purpose: port-level assertions for the keyboard input port
// Assumes: board settings held steady while reads run
// Notes:   switch copy mirrors the two-flop synchroniser
`timescale 1ns/1ns
module kip_chk (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RESET,
  // keyboard and settings
  input wire logic       KBD_STROBE,
  input wire logic       STROBE_POLARITY_SELECT,
  input wire logic [2:0] INTERRUPT_PRIORITY_SELECT,
  input wire logic [5:0] ADDR_SWITCH,
  // port access
  input wire logic [7:0] PORT_ADDR,
  input wire logic       PORT_READ,
  input wire logic       STATUS_READ,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE,
  input wire logic       INT_REQ,
  input wire logic [7:0] INT_VECTOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [5:0] sw_q1;
  logic [5:0] sw_q2;
  logic       hit;
  // switch copy two cycles late, as the design sees it
  always_ff @(posedge CLK) begin
    sw_q1 <= ADDR_SWITCH;
    sw_q2 <= sw_q1;
  end
  assign hit = (PORT_ADDR[7:2] == sw_q2);

  read_ans_a: assert property (
    (PORT_READ || STATUS_READ) && hit |=> DATA_OE)
    else $error("read not answered");
  addr_refuse_a: assert property (
    !((PORT_READ || STATUS_READ) && hit) |=> !DATA_OE && DATA_OUT == 8'h00)
    else $error("answer without selected read");
  stat_irq_a: assert property (
    STATUS_READ && !PORT_READ && hit |=> DATA_OUT[6:0] == {6'h00, $past(INT_REQ)})
    else $error("status low bits wrong");
  stat_stb_a: assert property (
    STATUS_READ && !PORT_READ && hit && $stable(KBD_STROBE)
    && KBD_STROBE == $past(KBD_STROBE, 2) && KBD_STROBE == $past(KBD_STROBE, 3)
    |=> DATA_OUT[7] == $past(KBD_STROBE))
    else $error("status strobe bit wrong");
  key_irq_a: assert property (
    (STROBE_POLARITY_SELECT ? $fell(KBD_STROBE) : $rose(KBD_STROBE)) |-> ##[3:5] INT_REQ)
    else $error("keypress did not raise request");
  irq_hold_a: assert property (
    INT_REQ && !(PORT_READ && hit) |=> INT_REQ)
    else $error("request dropped without data read");
  irq_vec_a: assert property (
    INT_REQ && $stable(INTERRUPT_PRIORITY_SELECT)
    && INTERRUPT_PRIORITY_SELECT == $past(INTERRUPT_PRIORITY_SELECT, 3)
    |-> INT_VECTOR == (8'h01 << INTERRUPT_PRIORITY_SELECT))
    else $error("vector line wrong");
  vec_idle_a: assert property (
    !INT_REQ |-> INT_VECTOR == 8'h00)
    else $error("vector without request");
endmodule // kip_chk

// *** tb/kip_kbd.sv ***
// Purpose: keyboard model, one strobe pulse per key
// Assumes: strobe idles at the polarity setting
// Notes:   data lines toggle every cycle between keys
`timescale 1ns/1ns
module kip_kbd (
  // clock and strobe sense
  input  wire logic       clk,
  input  wire logic       pol,
  // keyboard connector
  output logic      [7:0] kbd_data,
  output logic            kbd_strobe
);
  int         cnt  = 0;
  logic [7:0] ch_q = 8'h00;
  initial kbd_data = 8'h5A;
  initial kbd_strobe = 1'b0;
  // three-cycle strobe inside twelve data cycles
  always @(posedge clk) begin
    if (cnt != 0) cnt <= cnt - 1;
    kbd_data   <= (cnt != 0) ? ch_q : ~kbd_data;
    kbd_strobe <= (cnt <= 8 && cnt > 5) ? ~pol : pol;
  end
  // one key, returns once the strobe is idle again
  task automatic press(logic [7:0] ch);
    @(posedge clk);
    ch_q <= ch;
    cnt  <= 12;
    repeat (14) @(posedge clk);
  endtask
endmodule // kip_kbd

// *** tb/tb.sv ***
// Purpose: self-checking bench for the keyboard input port
// Assumes: nine keys fit: eight buffered plus the hold latch
// Notes:   queue model predicts every selected read
`timescale 1ns/1ns
module tb;
  logic       CLK = 1'b0;
  logic       RESET = 1'b1;
  logic       pol = 1'b0;
  logic [2:0] prio = 3'h0;
  logic [5:0] sw = 6'h00;
  logic [7:0] addr = 8'h00;
  logic       rd = 1'b0;
  logic       srd = 1'b0;
  logic [7:0] kd, dout, vec, got;
  logic       ks, oe, irq;
  int         n_mismatch = 0;
  int         n_checks = 0;
  logic [7:0] q[$];
  logic [7:0] last_ch = 8'h00;

  always #5 CLK = ~CLK;
  kip_top DUT (.CLK(CLK), .RESET(RESET), .KBD_DATA(kd), .KBD_STROBE(ks),
    .STROBE_POLARITY_SELECT(pol), .INTERRUPT_PRIORITY_SELECT(prio), .ADDR_SWITCH(sw),
    .PORT_ADDR(addr), .PORT_READ(rd), .STATUS_READ(srd), .DATA_OUT(dout), .DATA_OE(oe),
    .INT_REQ(irq), .INT_VECTOR(vec));
  kip_kbd kbd (.clk(CLK), .pol(pol), .kbd_data(kd), .kbd_strobe(ks));

  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one read strobe, answer looked at in the following cycle
  task automatic bus_rd(logic d, logic s, logic [7:0] a, logic eoe);
    @(posedge CLK);
    rd   <= d;
    srd  <= s;
    addr <= a;
    @(posedge CLK);
    rd  <= 1'b0;
    srd <= 1'b0;
    #1;
    got = dout;
    chk("oe", {7'h00, eoe}, {7'h00, oe});
  endtask
  task automatic read_key(logic s);
    logic [7:0] e;
    e = (q.size() != 0) ? q.pop_front() : last_ch;
    last_ch = e;
    bus_rd(1'b1, s, {sw, 2'($urandom)}, 1'b1);
    chk("data", e, got);
    chk("irq", {7'h00, q.size() != 0}, {7'h00, irq});
  endtask
  task automatic read_stat;
    bus_rd(1'b0, 1'b1, {sw, 2'($urandom)}, 1'b1);
    chk("status", {pol, 6'h00, q.size() != 0}, got);
  endtask
  task automatic key(logic [7:0] ch);
    int i;
    kbd.press(ch);
    if (q.size() < 9) q.push_back(ch);
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge CLK);
    if (i == 20) begin
      n_mismatch++;
      $display("CHECK FAILED irq expected 1 seen %b", irq);
    end
    chk("vector", 8'h01 << prio, vec);
  endtask
  task automatic do_reset(logic p);
    @(posedge CLK);
    RESET <= 1'b1;
    pol   <= p;
    prio  <= 3'($urandom);
    sw    <= 6'($urandom);
    q.delete();
    last_ch = 8'h00;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  initial begin
    void'($urandom(11388));
    for (int p = 0; p < 2; p++) begin
      do_reset(p[0]);
      chk("reset irq", 8'h00, {7'h00, irq});
      read_stat;
      key(8'($urandom));
      read_stat;
      read_key(1'b0);
      read_key(1'b0);
      chk("idle vector", 8'h00, vec);
      bus_rd(1'b1, 1'b0, {~sw, 2'($urandom)}, 1'b0);
      $display("polarity %0d test done", p);
    end
    for (int i = 0; i < 11; i++) key(8'($urandom));
    read_stat;
    for (int i = 0; i < 11; i++) read_key(1'b0);
    $display("fill and drain test done");
    key(8'($urandom));
    read_key(1'b1);
    $display("data over status test done");
    close_out();
  end
endmodule // tb

bind kip_top kip_chk u_chk (.CLK(CLK), .RESET(RESET), .KBD_STROBE(KBD_STROBE),
  .STROBE_POLARITY_SELECT(STROBE_POLARITY_SELECT),
  .INTERRUPT_PRIORITY_SELECT(INTERRUPT_PRIORITY_SELECT), .ADDR_SWITCH(ADDR_SWITCH),
  .PORT_ADDR(PORT_ADDR), .PORT_READ(PORT_READ), .STATUS_READ(STATUS_READ),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR));
